// File: src/ssfl_pkg.sv
// Constants, register map and carrier types of the safe-state fault logic
package ssfl_pkg;

  // Clock and timing
  localparam int CLK_PERIOD_NS = 20;
  localparam int WDOG_MIN_NS = 2200000; // Window opens 2.2 ms after a kick
  localparam int WDOG_MAX_NS = 9300000; // Window closes 9.3 ms after a kick
  localparam int WDOG_HOLD_NS = 1000000; // Fault output low time
  // Least time rounds up, longest time rounds down
  localparam int WDOG_MIN_CYC = (WDOG_MIN_NS + CLK_PERIOD_NS - 1)
                                / CLK_PERIOD_NS;
  localparam int WDOG_MAX_CYC = WDOG_MAX_NS / CLK_PERIOD_NS;
  localparam int WDOG_HOLD_CYC = WDOG_HOLD_NS / CLK_PERIOD_NS;
  localparam int WDOG_CNT_W = 20;

  // Channel count and register bus widths
  localparam int NUM_CHANNELS = 8;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;

  // Register byte offsets
  localparam logic [7:0] REG_CONTROL = 8'h00;
  localparam logic [7:0] REG_TEST_ENABLE = 8'h04;
  localparam logic [7:0] REG_TEST_LEVEL = 8'h08;
  localparam logic [7:0] REG_STATUS = 8'h0C;

  // Control register fields
  localparam int CTRL_COLD_MASK_BIT = 0;
  localparam int CTRL_WARM_MASK_BIT = 1;

  // Reset values
  localparam logic [7:0] TEST_ENABLE_RST = 8'hFF;
  localparam logic [7:0] TEST_LEVEL_RST = 8'h00;
  localparam logic [31:0] READ_ZERO = 32'h0000_0000;

  // Watchdog states
  typedef enum logic [1:0] {
    SSFL_WD_RUN,
    SSFL_WD_FAULT
  } ssfl_wd_state_t;

  // Rail and controller fault flags, all active low
  typedef struct packed {
    logic core_rail_undervolt_n;
    logic core_rail_overvolt_n;
    logic io_rail_undervolt_n;
    logic mcu_fault_n;
  } ssfl_fault_pins_t;

  // Status word, bit 5 down to bit 0
  typedef struct packed {
    logic warm_line_low;
    logic watchdog_fault;
    logic overvolt_latched;
    logic warm_request;
    logic cold_request;
    logic safe_state;
  } ssfl_status_t;

  localparam int STATUS_W = $bits(ssfl_status_t);

endpackage : ssfl_pkg

// File: src/ssfl_chan_diag.sv
// One channel's diagnostic injection driver
`timescale 1ns/1ps
module ssfl_chan_diag (
  input wire logic clock,
  input wire logic srst,
  input wire logic test_enable_n,
  input wire logic test_level,
  output logic inject_out_r,
  output logic inject_oe_n_r
);

  // Driver floats unless the channel test is enabled
  always_ff @(posedge clock) begin
    if (srst) begin
      inject_oe_n_r <= 1'b1;
      inject_out_r <= 1'b0;
    end else begin
      inject_oe_n_r <= test_enable_n;
      inject_out_r <= test_level;
    end
  end

endmodule : ssfl_chan_diag

// File: src/ssfl_safe_state_logic.sv
// Safe-state, reset request, watchdog and channel test logic
//
// Design decisions made here: the address map and the address-and-strobe port.
`timescale 1ns/1ps
// Summary of operation
// - Test drivers float in normal operation
// - Only controller-affecting faults enter safe state
// - Any cold or warm request enters safe state
// - Rail faults cold reset; error, watchdog warm
// - Core undervolt resets while present, latch untouched
// - Core overvolt latch holds cold reset until power-off
// - Power-up rail sequence leaves latch untripped
// - I/O undervolt resets while present
// - Controller error causes warm reset, safe state
// - Kicks strictly inside window, else watchdog fault
// - Safe state cuts isolator field power
// - Warm line bidirectional; mask blocks warm reset only
// - Unpowered field side forces reply output low
// - Masks never block the safe-state trigger
// - Reply line idles high between transfers
// - Names ending _n are active low
// - Cold mask blocks cold reset, not safe state
module ssfl_safe_state_logic
  import ssfl_pkg::*;
#(
  parameter int N_CHAN = NUM_CHANNELS,
  parameter int WD_MIN_CYCLES = WDOG_MIN_CYC,
  parameter int WD_MAX_CYCLES = WDOG_MAX_CYC,
  parameter int WD_HOLD_CYCLES = WDOG_HOLD_CYC
) (
  input wire logic clock,
  input wire logic srst,
  // Register port
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [DATA_W-1:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [DATA_W-1:0] reg_rdata,
  // Fault flags
  input wire ssfl_fault_pins_t fault_pins,
  // Watchdog
  input wire logic watchdog_kick_input,
  output logic watchdog_fault_out_n,
  // Controller resets
  output logic cold_reset_pin_n,
  input wire logic warm_restart_line_in,
  output logic warm_restart_line_out,
  output logic warm_restart_line_oe_n,
  // Permanent core overvoltage indication
  output logic core_overvolt_latched_n,
  // Isolator field side
  output logic field_power_enable,
  input wire logic isolated_channel_d_in,
  output logic isolated_channel_d_out,
  // Channel test injection
  output logic [N_CHAN-1:0] channel_inject_out,
  output logic [N_CHAN-1:0] channel_inject_oe_n
);

  // Software control state
  logic cold_mask_r;
  logic warm_mask_r;
  logic [N_CHAN-1:0] channel_test_enable_n_r;
  logic [N_CHAN-1:0] channel_test_level_r;
  logic [DATA_W-1:0] rdata_r;

  // Overvoltage latch state
  logic ov_armed_r;
  logic ov_latch_r;

  // Watchdog state
  ssfl_wd_state_t wd_state_r;
  logic [WDOG_CNT_W-1:0] wd_cnt_r;
  logic kick_prev_r;
  logic wd_fault_r;

  // Combined requests
  logic kick_fall;
  logic kick_early;
  logic kick_late;
  logic cold_request;
  logic warm_request;
  logic safe_trigger;
  ssfl_status_t status;

  // Output flip-flops
  logic cold_reset_pin_n_r;
  logic warm_oe_n_r;
  logic field_power_r;
  logic d_out_r;
  logic ov_latched_n_r;
  logic wd_out_n_r;

  // Window limits at counter width; the counter reads one less than the
  // cycles since its restart, so the late bound sits one count lower
  localparam logic [WDOG_CNT_W-1:0] WD_MIN =
    WDOG_CNT_W'(WD_MIN_CYCLES);
  localparam logic [WDOG_CNT_W-1:0] WD_LAST =
    WDOG_CNT_W'(WD_MAX_CYCLES - 1);
  localparam logic [WDOG_CNT_W-1:0] WD_HOLD =
    WDOG_CNT_W'(WD_HOLD_CYCLES);

  // Register writes
  always_ff @(posedge clock) begin
    if (srst) begin
      cold_mask_r <= 1'b0;
      warm_mask_r <= 1'b0;
      channel_test_enable_n_r <= N_CHAN'(TEST_ENABLE_RST);
      channel_test_level_r <= N_CHAN'(TEST_LEVEL_RST);
    end else if (reg_write) begin
      unique case (reg_addr)
        REG_CONTROL: begin
          cold_mask_r <= reg_wdata[CTRL_COLD_MASK_BIT];
          warm_mask_r <= reg_wdata[CTRL_WARM_MASK_BIT];
        end
        REG_TEST_ENABLE: begin
          channel_test_enable_n_r <= reg_wdata[N_CHAN-1:0];
        end
        REG_TEST_LEVEL: begin
          channel_test_level_r <= reg_wdata[N_CHAN-1:0];
        end
        default: begin
          // Status is read only; other addresses ignore writes
        end
      endcase
    end
  end

  // Register reads, data valid in the next cycle only
  always_ff @(posedge clock) begin
    if (srst) begin
      rdata_r <= READ_ZERO;
    end else if (reg_read) begin
      unique case (reg_addr)
        REG_CONTROL: begin
          rdata_r <= READ_ZERO;
          rdata_r[CTRL_COLD_MASK_BIT] <= cold_mask_r;
          rdata_r[CTRL_WARM_MASK_BIT] <= warm_mask_r;
        end
        REG_TEST_ENABLE: begin
          rdata_r <= DATA_W'(channel_test_enable_n_r);
        end
        REG_TEST_LEVEL: begin
          rdata_r <= DATA_W'(channel_test_level_r);
        end
        REG_STATUS: begin
          rdata_r <= DATA_W'(status);
        end
        default: begin
          rdata_r <= READ_ZERO;
        end
      endcase
    end else begin
      rdata_r <= READ_ZERO;
    end
  end

  // Overvoltage latch arms once the flag has gone high at power-up
  always_ff @(posedge clock) begin
    if (srst) begin
      ov_armed_r <= 1'b0;
    end else if (fault_pins.core_rail_overvolt_n) begin
      ov_armed_r <= 1'b1;
    end
  end

  // Latch sets on overvoltage and clears only on power-on reset
  always_ff @(posedge clock) begin
    if (srst) begin
      ov_latch_r <= 1'b0;
    end else if (ov_armed_r && !fault_pins.core_rail_overvolt_n) begin
      ov_latch_r <= 1'b1;
    end
  end

  // Falling kick edge and window checks
  assign kick_fall = kick_prev_r && !watchdog_kick_input;
  assign kick_early = kick_fall && (wd_cnt_r < WD_MIN);
  assign kick_late = (wd_cnt_r >= WD_LAST);

  // Previous kick level for edge detection
  always_ff @(posedge clock) begin
    if (srst) begin
      kick_prev_r <= 1'b1;
    end else begin
      kick_prev_r <= watchdog_kick_input;
    end
  end

  // Window watchdog: counter restarts on each valid kick
  always_ff @(posedge clock) begin
    if (srst) begin
      wd_state_r <= SSFL_WD_RUN;
      wd_cnt_r <= '0;
      wd_fault_r <= 1'b0;
    end else begin
      unique case (wd_state_r)
        SSFL_WD_RUN: begin
          if (kick_early || kick_late) begin
            wd_state_r <= SSFL_WD_FAULT;
            wd_fault_r <= 1'b1;
            wd_cnt_r <= '0;
          end else if (kick_fall) begin
            wd_cnt_r <= '0;
          end else begin
            wd_cnt_r <= wd_cnt_r + 1'b1;
          end
        end
        SSFL_WD_FAULT: begin
          if (wd_cnt_r >= WD_HOLD) begin
            wd_state_r <= SSFL_WD_RUN;
            wd_fault_r <= 1'b0;
            wd_cnt_r <= '0;
          end else begin
            wd_cnt_r <= wd_cnt_r + 1'b1;
          end
        end
      endcase
    end
  end

  // Cold request: core under/over voltage, I/O undervoltage
  assign cold_request = !fault_pins.core_rail_undervolt_n
                        || ov_latch_r
                        || (ov_armed_r && !fault_pins.core_rail_overvolt_n)
                        || !fault_pins.io_rail_undervolt_n;

  // Warm request: controller error or watchdog failure
  assign warm_request = !fault_pins.mcu_fault_n
                        || wd_fault_r;

  // Safe state from either request or the shared warm line, never masked
  assign safe_trigger = cold_request || warm_request
                        || !warm_restart_line_in;

  // Status snapshot for software
  assign status = '{
    warm_line_low: !warm_restart_line_in,
    watchdog_fault: wd_fault_r,
    overvolt_latched: ov_latch_r,
    warm_request: warm_request,
    cold_request: cold_request,
    safe_state: !field_power_r
  };

  // Controller reset outputs, masks only gate the reset paths
  always_ff @(posedge clock) begin
    if (srst) begin
      cold_reset_pin_n_r <= 1'b0;
      warm_oe_n_r <= 1'b1;
    end else begin
      cold_reset_pin_n_r <= !(cold_request && !cold_mask_r);
      warm_oe_n_r <= !(warm_request && !warm_mask_r);
    end
  end

  // Isolator field power and reply line
  always_ff @(posedge clock) begin
    if (srst) begin
      field_power_r <= 1'b0;
      d_out_r <= 1'b0;
    end else begin
      field_power_r <= !safe_trigger;
      // Unpowered field side pulls reply low; idle high otherwise
      d_out_r <= !safe_trigger && isolated_channel_d_in;
    end
  end

  // Indications
  always_ff @(posedge clock) begin
    if (srst) begin
      ov_latched_n_r <= 1'b1;
      wd_out_n_r <= 1'b1;
    end else begin
      ov_latched_n_r <= !ov_latch_r;
      wd_out_n_r <= !wd_fault_r;
    end
  end

  // One injection driver per channel
  for (genvar ch = 0; ch < N_CHAN; ch++) begin : g_chan
    ssfl_chan_diag u_diag (
      .clock(clock),
      .srst(srst),
      .test_enable_n(channel_test_enable_n_r[ch]),
      .test_level(channel_test_level_r[ch]),
      .inject_out_r(channel_inject_out[ch]),
      .inject_oe_n_r(channel_inject_oe_n[ch])
    );
  end

  // Output wiring, all from flip-flops except the warm line data tied low
  assign reg_rdata = rdata_r;
  assign cold_reset_pin_n = cold_reset_pin_n_r;
  assign warm_restart_line_out = 1'b0; // Warm line is only pulled low
  assign warm_restart_line_oe_n = warm_oe_n_r;
  assign field_power_enable = field_power_r;
  assign isolated_channel_d_out = d_out_r;
  assign core_overvolt_latched_n = ov_latched_n_r;
  assign watchdog_fault_out_n = wd_out_n_r;

endmodule : ssfl_safe_state_logic

// File: testbench/ssfl_safe_state_logic_monitor.sv
// Checker of the safe-state outputs
`timescale 1ns/1ps
module ssfl_chk
  import ssfl_pkg::*;
(
  input wire logic clock,
  input wire logic srst,
  input wire logic reg_read,
  input wire logic [DATA_W-1:0] reg_rdata,
  input wire ssfl_fault_pins_t fault_pins,
  input wire logic watchdog_fault_out_n,
  input wire logic cold_reset_pin_n,
  input wire logic warm_restart_line_in,
  input wire logic core_overvolt_latched_n,
  input wire logic field_power_enable,
  input wire logic isolated_channel_d_in,
  input wire logic isolated_channel_d_out
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (srst);
  safe_rail_a: assert property (
    !fault_pins.core_rail_undervolt_n || !fault_pins.io_rail_undervolt_n
    || !fault_pins.mcu_fault_n |=> !field_power_enable)
    else $error("fault without safe state");
  cold_safe_a: assert property (
    $fell(cold_reset_pin_n) |-> !field_power_enable)
    else $error("cold reset without safe state");
  warm_line_a: assert property (
    !warm_restart_line_in |=> !field_power_enable)
    else $error("warm line low without safe state");
  wdog_safe_a: assert property (
    $fell(watchdog_fault_out_n) |=> !field_power_enable [*4])
    else $error("watchdog fault without safe state");
  wdog_hold_a: assert property (
    $fell(watchdog_fault_out_n) |-> !watchdog_fault_out_n [*8])
    else $error("watchdog fault too short");
  rd_idle_a: assert property (
    !$past(reg_read) |-> reg_rdata == '0)
    else $error("read data outside its cycle");
  ovl_hold_a: assert property (
    !core_overvolt_latched_n |=>
    !core_overvolt_latched_n && !field_power_enable)
    else $error("overvoltage latch released");
  ovl_clean_a: assert property (
    $rose(fault_pins.core_rail_undervolt_n) && core_overvolt_latched_n
    |=> core_overvolt_latched_n)
    else $error("latch tripped by undervoltage");
  dout_low_a: assert property (
    !field_power_enable |-> !isolated_channel_d_out)
    else $error("reply high in safe state");
  dout_pass_a: assert property (
    field_power_enable |->
    isolated_channel_d_out == $past(isolated_channel_d_in))
    else $error("reply not passed through");
endmodule : ssfl_chk
bind ssfl_safe_state_logic ssfl_chk u_chk (.clock, .srst, .reg_read,
  .reg_rdata, .fault_pins, .watchdog_fault_out_n, .cold_reset_pin_n,
  .warm_restart_line_in, .core_overvolt_latched_n, .field_power_enable,
  .isolated_channel_d_in, .isolated_channel_d_out);

// File: testbench/ssfl_master_model.sv
// Controller reply source and master sampling on the isolated link
`timescale 1ns/1ps
module ssfl_master_model (
  input wire logic clock,
  input wire logic frame_on,
  input wire logic reply_line,
  output logic reply_drive,
  output logic safe_seen
);
  logic [7:0] sr_r = 8'h5A;
  initial reply_drive = 1'b1;
  initial safe_seen = 1'b0;
  // Reply idles high outside frames, changing pattern inside
  always @(posedge clock) begin
    sr_r <= {sr_r[6:0], sr_r[7] ^ sr_r[5]};
    reply_drive <= frame_on ? sr_r[0] : 1'b1;
  end
  // Master takes a low idle line as the safe state
  always @(posedge clock) safe_seen <= !frame_on && !reply_line;
endmodule : ssfl_master_model

// File: testbench/ssfl_safe_state_logic_tb.sv
// Testbench of the safe-state fault logic
`timescale 1ns/1ps
module ssfl_safe_state_logic_tb import ssfl_pkg::*;;
  logic clock = 1'b0;
  logic srst = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_write = 1'b0;
  logic reg_read = 1'b0;
  logic [31:0] reg_rdata;
  ssfl_fault_pins_t fp = 4'h7;
  logic kick = 1'b1, ext_n = 1'b1, frame_on = 1'b0, kick_on = 1'b0;
  logic rd_d = 1'b0;
  logic [31:0] rnd = 32'h0AB7;
  logic wdo, cold_n, w_in, w_out, w_oe_n, ovl_n, fpe, d_in, d_out, seen;
  logic [7:0] inj, inj_oe_n;
  logic [31:0] q[$];
  int miscompares = 0;
  int num_checks = 0;
  // Clock and warm wire resolution
  always #10 clock = ~clock;
  assign w_in = ext_n & (w_oe_n | w_out);
  ssfl_safe_state_logic #(.WD_MIN_CYCLES(20), .WD_MAX_CYCLES(60),
    .WD_HOLD_CYCLES(10)) DUT (.clock, .srst, .reg_addr, .reg_wdata,
    .reg_write, .reg_read, .reg_rdata, .fault_pins(fp),
    .watchdog_kick_input(kick), .watchdog_fault_out_n(wdo),
    .cold_reset_pin_n(cold_n), .warm_restart_line_in(w_in),
    .warm_restart_line_out(w_out), .warm_restart_line_oe_n(w_oe_n),
    .core_overvolt_latched_n(ovl_n), .field_power_enable(fpe),
    .isolated_channel_d_in(d_in), .isolated_channel_d_out(d_out),
    .channel_inject_out(inj), .channel_inject_oe_n(inj_oe_n));
  ssfl_master_model PM (.clock, .frame_on, .reply_line(d_out),
    .reply_drive(d_in), .safe_seen(seen));
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
  endtask : tick
  task automatic chk(input logic [31:0] s, input logic [31:0] e,
    input string nm);
    num_checks++;
    if (s !== e) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", nm, e, s);
    end
  endtask : chk
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : print_verdict
  // Bus cycles; strobes drop for one cycle between accesses
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    tick(1);
    reg_write <= 1'b0;
    tick(1);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    q.push_back(e);
    reg_addr <= a;
    reg_read <= 1'b1;
    tick(1);
    reg_read <= 1'b0;
    tick(1);
  endtask : rd
  task automatic kick1;
    kick <= 1'b0;
    tick(1);
    kick <= 1'b1;
    tick(1);
  endtask : kick1
  task automatic wait_wdo(input logic lv, input int n);
    for (int i = 0; i < n && wdo !== lv; i++) @(negedge clock);
    chk({31'h0, wdo}, {31'h0, lv}, "wdo");
    if (wdo !== lv) print_verdict();
    else tick(1);
  endtask : wait_wdo
  // Read data taken off the oldest note in the cycle after the strobe
  always @(posedge clock) rd_d <= reg_read;
  always @(negedge clock) if (rd_d === 1'b1)
    chk(reg_rdata, q.pop_front(), "rdata");
  // Background kicks at a spacing inside the window
  always begin
    wait (kick_on);
    tick(40);
    kick <= 1'b0;
    tick(1);
    kick <= 1'b1;
  end
  // Overall limit on the run
  initial begin
    tick(20000);
    miscompares++;
    print_verdict();
  end
  // Main sequence
  initial begin
    int b, m;
    tick(20);
    srst <= 1'b0;
    tick(3);
    fp <= 4'hF;
    tick(3);
    @(negedge clock);
    chk({30'h0, ovl_n, fpe}, 32'h3, "powerup");
    chk({24'h0, inj_oe_n}, 32'hFF, "float");
    tick(24);
    kick1();
    tick(19);
    kick1();
    @(negedge clock);
    chk({31'h0, wdo}, 32'h1, "window");
    tick(18);
    kick1();
    wait_wdo(1'b0, 5);
    wait_wdo(1'b1, 20);
    wait_wdo(1'b0, 80);
    wait_wdo(1'b1, 20);
    kick_on <= 1'b1;
    rd(REG_TEST_ENABLE, 32'hFF);
    rd(8'h10, 32'h0);
    rnd = lfsr(rnd);
    wr(REG_TEST_LEVEL, rnd);
    wr(REG_TEST_ENABLE, {24'h0, rnd[15:8]});
    @(negedge clock);
    chk({24'h0, inj}, {24'h0, rnd[7:0]}, "level");
    chk({24'h0, inj_oe_n}, {24'h0, rnd[15:8]}, "enable");
    tick(1);
    wr(REG_STATUS, 32'hFFFFFFFF);
    rd(REG_TEST_LEVEL, {24'h0, rnd[7:0]});
    rd(REG_STATUS, 32'h0);
    for (m = 0; m < 2; m++) begin
      wr(REG_CONTROL, m != 0 ? 32'h3 : 32'h0);
      rd(REG_CONTROL, m != 0 ? 32'h3 : 32'h0);
      for (b = 0; b < 3; b++) begin
        fp <= ~(4'h1 << (b == 2 ? 3 : b));
        tick(3);
        @(negedge clock);
        chk({31'h0, fpe}, 32'h0, "power");
        chk({30'h0, cold_n, w_oe_n}, {30'h0, b == 0 || m != 0,
          b != 0 || m != 0}, "resets");
        tick(1);
        rd(REG_STATUS, b != 0 ? 32'h3 : m != 0 ? 32'h5 : 32'h25);
        fp <= 4'hF;
        tick(3);
        @(negedge clock);
        chk({30'h0, fpe, ovl_n}, 32'h3, "back");
        tick(1);
      end
    end
    ext_n <= 1'b0;
    tick(4);
    @(negedge clock);
    chk({29'h0, fpe, seen, w_out}, 32'h2, "warm");
    tick(1);
    ext_n <= 1'b1;
    frame_on <= 1'b1;
    tick(20);
    frame_on <= 1'b0;
    tick(3);
    @(negedge clock);
    chk({31'h0, seen}, 32'h0, "idle");
    tick(1);
    wr(REG_CONTROL, 32'h0);
    fp <= 4'hB;
    tick(1);
    fp <= 4'hF;
    tick(5);
    @(negedge clock);
    chk({29'h0, ovl_n, fpe, cold_n}, 32'h0, "latch");
    tick(1);
    rd(REG_STATUS, 32'hB);
    srst <= 1'b1;
    tick(2);
    srst <= 1'b0;
    tick(3);
    @(negedge clock);
    chk({31'h0, ovl_n}, 32'h1, "cleared");
    tick(2);
    print_verdict();
  end
endmodule : ssfl_safe_state_logic_tb
